// ---- src/tec_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module tec_timer
    import tec_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic count_input_pin,
    output logic [1:0] timer_output_pins,
    output logic irq
);
    import tec_pkg::*;

    logic countEnable_q;
    logic clearMode_q;
    logic overflowFlag_q;
    logic oneShot_q;
    logic extMode_q;
    logic clearOnOne_q;
    logic [PRESC_W-1:0] prescalerSelectOne_q;
    logic [5:0] timerOutputControl_q;
    logic [CNT_W-1:0] matchValue_q [2];
    logic [CNT_W-1:0] captureHold_q;
    logic [CNT_W-1:0] eventTimerCount_q;
    logic [ST_W-1:0] status_q;
    logic [ST_W-1:0] mask_q;
    logic [1:0] pinLevel_q;
    logic started_q;
    logic seenEdge_q;
    logic [7:0] awAddr_q;
    logic awHeld_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic wHeld_q;
    tec_wr_t wr;
    logic wrFire;
    logic presTick;
    logic extRise;
    logic countTick;
    logic incr;
    logic [1:0] matchHit;
    logic [1:0] matchWrite;
    logic wrapCount;
    logic ovfClearWrite;
    logic [1:0] omode;

    ////////////////////////////////////////////////////////////////////////
    tec_prescaler u_prescaler (
        .clk(clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .run(countEnable_q),
        .select(prescalerSelectOne_q),
        .tick(presTick)
    );

    tec_edge_sync u_edge (
        .clk(clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .pinIn(count_input_pin),
        .rise(extRise)
    );

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write: address and data are taken in either order.
    assign wr = '{addr: awAddr_q, data: wData_q, strb: wStrb_q};
    assign wrFire = awHeld_q && wHeld_q && !s_axi_bvalid;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            awHeld_q <= 1'b0;
            wHeld_q <= 1'b0;
            awAddr_q <= 8'h00;
            wData_q <= 32'h0000_0000;
            wStrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= AXI_OKAY;
        end
        else if (clkEn)
        begin
            s_axi_awready <= !awHeld_q && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !wHeld_q && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wrFire)
            begin
                awHeld_q <= 1'b0;
                wHeld_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr.addr[1:0] == 2'h0
                    && wr.addr <= ADDR_MASK) ? AXI_OKAY : AXI_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    assign ovfClearWrite = wrFire && wr.addr == ADDR_CONTROL && wr.strb[0]
        && !wr.data[CTL_OVF] && overflowFlag_q;

    // Only the low byte lane carries register bits.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            clearMode_q <= 1'b0;
            oneShot_q <= 1'b0;
            extMode_q <= 1'b0;
            clearOnOne_q <= 1'b0;
            prescalerSelectOne_q <= PRESC_RESET;
            timerOutputControl_q <= 6'h00;
            mask_q <= '1;
        end
        else if (clkEn && wrFire && wr.strb[0])
        begin
            unique case (wr.addr)
                ADDR_CONTROL:
                begin
                    clearMode_q <= wr.data[CTL_CLEAR];
                    oneShot_q <= wr.data[CTL_ONESHOT];
                end
                ADDR_PRESCALE: prescalerSelectOne_q <= wr.data[PRESC_W-1:0];
                ADDR_MODE:
                begin
                    extMode_q <= wr.data[MODE_EXT];
                    clearOnOne_q <= wr.data[MODE_CLR_M1];
                end
                ADDR_OUTCTL: timerOutputControl_q <= wr.data[5:0];
                ADDR_MASK: mask_q <= wr.data[ST_W-1:0];
                default:
                begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counting core.
    assign countTick = extMode_q ? (extRise && countEnable_q) : presTick;
    // The first valid edge only arms the counter.
    assign incr = countTick && started_q && (!extMode_q || seenEdge_q);
    assign wrapCount = clearMode_q && matchHit[clearOnOne_q];
    assign omode = timerOutputControl_q[OUT_MODE_LO+1:OUT_MODE_LO];

    generate
        for (genvar n = 0; n < 2; n++)
        begin : g_match
            tec_match_t cmp;
            assign matchWrite[n] = wrFire && wr.strb[0]
                && wr.addr == (n == 0 ? ADDR_MATCH0 : ADDR_MATCH1);
            assign cmp = '{valid: incr && !matchWrite[n],
                value: matchValue_q[n]};
            assign matchHit[n] = cmp.valid
                && (eventTimerCount_q + 8'h01) == cmp.value;

            always_ff @(posedge clk)
            begin
                if (!rst_n)
                    matchValue_q[n] <= MATCH_RESET;
                else if (clkEn && matchWrite[n])
                    matchValue_q[n] <= wr.data[CNT_W-1:0];
            end

            // A disabled output shows the inverse active level.
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                    pinLevel_q[n] <= 1'b0;
                else if (clkEn)
                begin
                    if (!timerOutputControl_q[2*n])
                        pinLevel_q[n] <= !timerOutputControl_q[2*n+1];
                    else if (!countEnable_q && omode == OMODE_PULSE)
                        pinLevel_q[n] <= timerOutputControl_q[2*n+1];
                    else if (matchHit[n] && omode == OMODE_TOGGLE)
                        pinLevel_q[n] <= !pinLevel_q[n];
                    else if (omode != OMODE_TOGGLE && incr
                        && (wrapCount || eventTimerCount_q == 8'hFF))
                        pinLevel_q[n] <= timerOutputControl_q[2*n+1];
                    else if (omode != OMODE_TOGGLE && matchHit[n])
                        pinLevel_q[n] <= !timerOutputControl_q[2*n+1];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            countEnable_q <= 1'b0;
            started_q <= 1'b0;
            seenEdge_q <= 1'b0;
            eventTimerCount_q <= 8'h00;
            overflowFlag_q <= 1'b0;
        end
        else if (clkEn)
        begin
            if (wrFire && wr.addr == ADDR_CONTROL && wr.strb[0])
            begin
                countEnable_q <= wr.data[CTL_CE];
                if (!wr.data[CTL_CE])
                begin
                    started_q <= 1'b0;
                    seenEdge_q <= 1'b0;
                    eventTimerCount_q <= 8'h00;
                end
            end
            // Counting waits for the first count clock after the start.
            if (countEnable_q && countTick && !started_q)
                started_q <= 1'b1;
            if (countEnable_q && extMode_q && extRise)
                seenEdge_q <= 1'b1;
            if (ovfClearWrite && oneShot_q)
            begin
                eventTimerCount_q <= 8'h00;
                started_q <= 1'b0;
            end
            else if (incr && !(oneShot_q && overflowFlag_q))
                eventTimerCount_q <= wrapCount ? 8'h00
                    : eventTimerCount_q + 8'h01;
            // Hardware setting wins over the software clear.
            if (incr && !overflowFlag_q && (eventTimerCount_q == 8'hFF
                || (oneShot_q && matchHit[0])))
                overflowFlag_q <= 1'b1;
            else if (ovfClearWrite)
                overflowFlag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            captureHold_q <= 8'h00;
        else if (clkEn && extRise)
            captureHold_q <= eventTimerCount_q;
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky events, write one to clear, set beats clear.
    always_ff @(posedge clk)
    begin
        logic [ST_W-1:0] setBits;
        logic [ST_W-1:0] clrBits;
        setBits = '0;
        clrBits = '0;
        if (!rst_n)
        begin
            status_q <= '0;
            irq <= 1'b0;
        end
        else if (clkEn)
        begin
            // A hit computed in the stop cycle still posts its flag.
            setBits[ST_M0] = matchHit[0] && !(oneShot_q && overflowFlag_q);
            setBits[ST_M1] = matchHit[1] && !(oneShot_q && overflowFlag_q);
            setBits[ST_OVF] = incr && !overflowFlag_q
                && (eventTimerCount_q == 8'hFF || (oneShot_q && matchHit[0]));
            setBits[ST_EXT] = extRise;
            if (wrFire && wr.addr == ADDR_STATUS && wr.strb[0])
                clrBits = wr.data[ST_W-1:0];
            status_q <= (status_q & ~clrBits) | setBits;
            irq <= |(((status_q & ~clrBits) | setBits) & ~mask_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read, one outstanding.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= AXI_OKAY;
        end
        else if (clkEn)
        begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= AXI_OKAY;
                unique case (s_axi_araddr)
                    ADDR_CONTROL: s_axi_rdata <= {28'h0, oneShot_q,
                        overflowFlag_q, clearMode_q, countEnable_q};
                    ADDR_PRESCALE: s_axi_rdata <= {28'h0, prescalerSelectOne_q};
                    ADDR_MODE: s_axi_rdata <= {30'h0, clearOnOne_q, extMode_q};
                    ADDR_OUTCTL: s_axi_rdata <= {26'h0, timerOutputControl_q};
                    ADDR_MATCH0: s_axi_rdata <= {24'h0, matchValue_q[0]};
                    ADDR_MATCH1: s_axi_rdata <= {24'h0, matchValue_q[1]};
                    ADDR_CAPTURE: s_axi_rdata <= {24'h0, captureHold_q};
                    ADDR_COUNT: s_axi_rdata <= {24'h0, eventTimerCount_q};
                    ADDR_STATUS: s_axi_rdata <= {28'h0, status_q};
                    ADDR_MASK: s_axi_rdata <= {28'h0, mask_q};
                    default:
                    begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= AXI_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            timer_output_pins <= 2'h0;
        else if (clkEn)
            timer_output_pins <= pinLevel_q;
    end
endmodule : tec_timer
`default_nettype wire

// ---- src/tec_pkg.sv ----
package tec_pkg;

    // Register byte addresses on the AXI4-Lite slave.
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_PRESCALE = 8'h04;
    localparam logic [7:0] ADDR_MODE = 8'h08;
    localparam logic [7:0] ADDR_OUTCTL = 8'h0C;
    localparam logic [7:0] ADDR_MATCH0 = 8'h10;
    localparam logic [7:0] ADDR_MATCH1 = 8'h14;
    localparam logic [7:0] ADDR_CAPTURE = 8'h18;
    localparam logic [7:0] ADDR_COUNT = 8'h1C;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam logic [7:0] ADDR_MASK = 8'h24;

    // Control register fields.
    localparam int CTL_CE = 0;
    localparam int CTL_CLEAR = 1;
    localparam int CTL_OVF = 2;
    localparam int CTL_ONESHOT = 3;

    // Mode register fields.
    localparam int MODE_EXT = 0;
    localparam int MODE_CLR_M1 = 1;

    // Output control fields: bit 2n enable, bit 2n+1 active level,
    // bits 5:4 output mode.
    localparam int OUT_MODE_LO = 4;
    localparam logic [1:0] OMODE_TOGGLE = 2'h0;
    localparam logic [1:0] OMODE_PWM = 2'h1;
    localparam logic [1:0] OMODE_PULSE = 2'h2;

    // Status bits: match 0, match 1, overflow, external edge.
    localparam int ST_M0 = 0;
    localparam int ST_M1 = 1;
    localparam int ST_OVF = 2;
    localparam int ST_EXT = 3;
    localparam int ST_W = 4;

    localparam int CNT_W = 8;
    localparam int PRESC_W = 4;
    localparam int PRESC_MAX = 8;
    localparam logic [3:0] PRESC_RESET = 4'h0;
    localparam logic [7:0] MATCH_RESET = 8'hFF;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] data;
        logic [3:0] strb;
    } tec_wr_t;

    typedef struct packed {
        logic valid;
        logic [7:0] value;
    } tec_match_t;

endpackage : tec_pkg

// ---- src/tec_prescaler.sv ----
`timescale 1ns/1ps
`default_nettype none
module tec_prescaler
    import tec_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic run,
    input wire logic [tec_pkg::PRESC_W-1:0] select,
    output logic tick
);
    logic [10:0] div_q;
    logic [10:0] tap;

    // The divider runs freely, so a start waits up to one count clock.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            div_q <= 11'h000;
        else if (clkEn)
            div_q <= div_q + 11'h001;
    end

    always_comb
    begin
        tap = (11'h004 << select) - 11'h001;
        if (select > 4'(PRESC_MAX))
            tap = (11'h004 << PRESC_MAX) - 11'h001;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            tick <= 1'b0;
        else if (clkEn)
            tick <= run && ((div_q & tap) == tap);
    end
endmodule : tec_prescaler
`default_nettype wire

// ---- src/tec_edge_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module tec_edge_sync
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic pinIn,
    output logic rise
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_q <= 1'b0;
            rise <= 1'b0;
        end
        else if (clkEn)
        begin
            s1_q <= pinIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
            rise <= 1'b0;
            // A change counts only once two settled stages agree.
            if (s2_q == s3_q && s3_q != level_q)
            begin
                level_q <= s3_q;
                rise <= s3_q;
            end
        end
    end
endmodule : tec_edge_sync
`default_nettype wire

// ---- verification/tec_timer_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module tec_timer_properties
    import tec_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] timer_output_pins,
    input wire logic irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic [7:0] wAddr_q;
    logic [7:0] wData_q;
    logic wOk_q;
    logic bvld_q;
    logic [7:0] outCtl_q;
    ////////////////////////////////////////////////////////////////////
    // Shadow of the output control register, committed on the response.
    always_ff @(posedge clk)
    begin
        if (s_axi_awvalid && s_axi_awready)
            wAddr_q <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready)
            wOk_q <= s_axi_wstrb[0];
        if (s_axi_wvalid && s_axi_wready)
            wData_q <= s_axi_wdata[7:0];
        bvld_q <= s_axi_bvalid;
    end
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            outCtl_q <= 8'h00;
        else if (s_axi_bvalid && !bvld_q && s_axi_bresp == AXI_OKAY
                 && wAddr_q == ADDR_OUTCTL && wOk_q)
            outCtl_q <= wData_q;
    end
    ////////////////////////////////////////////////////////////////////
    a_write_answer: assert property ((s_axi_awvalid && s_axi_awready)
        |-> ##[1:20] s_axi_bvalid) else $error("write not answered");
    a_read_answer: assert property ((s_axi_arvalid && s_axi_arready)
        |=> s_axi_rvalid) else $error("read answer late");
    a_write_refused: assert property (s_axi_bvalid
        |-> !s_axi_awready && !s_axi_wready) else $error("write overlap");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read overlap");
    a_bvalid_single: assert property (s_axi_bvalid && s_axi_bready
        |=> !s_axi_bvalid) else $error("response repeated");
    a_reset_quiet: assert property (!$past(rst_n) |-> !s_axi_bvalid
        && !s_axi_rvalid && timer_output_pins == 2'h0 && !irq)
        else $error("outputs active after reset");
    a_upper_zero: assert property (s_axi_rvalid
        |-> s_axi_rdata[31:8] == 24'h000000) else $error("upper bits set");
    a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp ==
        AXI_SLVERR |-> s_axi_rdata == 32'h0) else $error("error read data");
    a_off_level0: assert property ((!outCtl_q[0] && $stable(outCtl_q))[*4]
        |-> timer_output_pins[0] == !outCtl_q[1]) else $error("pin0 level");
    a_off_level1: assert property ((!outCtl_q[2] && $stable(outCtl_q))[*4]
        |-> timer_output_pins[1] == !outCtl_q[3]) else $error("pin1 level");
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == AXI_SLVERR);
    c_irq: cover property ($rose(irq));
    c_toggle: cover property ($changed(timer_output_pins[0]));
endmodule : tec_timer_properties
bind tec_timer tec_timer_properties u_props (
    .clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .timer_output_pins, .irq
);
`default_nettype wire

// ---- verification/tec_pulse_source.sv ----
`timescale 1ns/1ps
`default_nettype none
module tec_pulse_source
(
    input wire logic clk,
    input wire logic go,
    input wire logic [3:0] pulses,
    output logic pin,
    output logic busy
);
    // Four cycles high and four low per pulse, above the synchroniser's
    // minimum width; the source drives the line low between bursts.
    logic [6:0] left_q = 7'h00;
    always_ff @(posedge clk)
    begin
        if (go)
            left_q <= {pulses, 3'h0};
        else if (left_q != 7'h00)
            left_q <= left_q - 7'h01;
    end
    assign pin = left_q[2];
    assign busy = left_q != 7'h00;
endmodule : tec_pulse_source
`default_nettype wire

// ---- verification/test_timer_event_counter_two.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_timer_event_counter_two;
    import tec_pkg::*;
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] d;
        logic [1:0] r;
    } tec_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic clkEn = 1'b1;
    logic s_axi_bready = 1'b1;
    logic s_axi_rready = 1'b1;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irq, count_input_pin, srcBusy, srcGo = 1'b0;
    logic [1:0] s_axi_bresp, s_axi_rresp, timer_output_pins, rs;
    logic [3:0] srcNum = 4'h0;
    int fail_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    int t0, t1, t2;
    tec_row_t rows [12] = '{
        '{ADDR_CONTROL, 32'h0, AXI_OKAY}, '{ADDR_MODE, 32'h0, AXI_OKAY},
        '{ADDR_PRESCALE, {28'h0, PRESC_RESET}, AXI_OKAY},
        '{ADDR_OUTCTL, 32'h0, AXI_OKAY}, '{ADDR_CAPTURE, 32'h0, AXI_OKAY},
        '{ADDR_MATCH0, {24'h0, MATCH_RESET}, AXI_OKAY},
        '{ADDR_MATCH1, {24'h0, MATCH_RESET}, AXI_OKAY},
        '{ADDR_COUNT, 32'h0, AXI_OKAY}, '{ADDR_STATUS, 32'h0, AXI_OKAY},
        '{ADDR_MASK, 32'hF, AXI_OKAY}, '{8'h28, 32'h0, AXI_SLVERR},
        '{8'h02, 32'h0, AXI_SLVERR}};
    tec_timer u_dut (.clk, .rst_n, .clkEn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .count_input_pin,
        .timer_output_pins, .irq);
    tec_pulse_source u_src (.clk, .go(srcGo), .pulses(srcNum),
        .pin(count_input_pin), .busy(srcBusy));
    ////////////////////////////////////////////////////////////////////
    initial
        forever #2 clk = ~clk;
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: %0h expected %0h", $time, seen, exp);
        end
    endtask : chk
    task tally_and_finish();
        $display("mismatches %0d, compares %0d", fail_count, cmp_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic axw(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        // Always pass an edge first: the last answer may still be showing.
        do
        begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
    endtask : axw
    task automatic axr(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
    endtask : axr
    task automatic pulse(input logic [3:0] k);
        srcNum <= k;
        srcGo <= 1'b1;
        @(posedge clk);
        srcGo <= 1'b0;
        @(posedge clk);
        for (int n = 0; n < 200 && srcBusy; n++)
            @(posedge clk);
        repeat (6) @(posedge clk);
    endtask : pulse
    task automatic nextEdge(output int t);
        logic p;
        p = timer_output_pins[0];
        for (int n = 0; n < 100 && timer_output_pins[0] === p; n++)
            @(posedge clk);
        t = cycles;
    endtask : nextEdge
    task automatic waitIrq();
        for (int n = 0; n < 300 && irq !== 1'b1; n++)
            @(posedge clk);
    endtask : waitIrq
    ////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        foreach (rows[i])
        begin
            axr(rows[i].a);
            chk(rd, rows[i].d);
            chk({30'h0, rs}, {30'h0, rows[i].r});
        end
        chk({30'h0, timer_output_pins}, 32'h3);
        axw(ADDR_OUTCTL, 32'h0A);
        repeat (4) @(posedge clk);
        chk({30'h0, timer_output_pins}, 32'h0);
        axw(8'h28, 32'h1);
        chk({30'h0, rs}, {30'h0, AXI_SLVERR});
        axw(ADDR_MASK, 32'h7);
        axw(ADDR_MODE, 32'h1);
        axw(ADDR_CONTROL, 32'h1);
        axr(ADDR_COUNT);
        chk(rd, 32'h0);
        chk({31'h0, irq}, 32'h0);
        pulse(4'h1);
        axr(ADDR_COUNT);
        chk(rd, 32'h0);
        axr(ADDR_STATUS);
        chk(rd, 32'h8);
        chk({31'h0, irq}, 32'h1);
        pulse(4'h3);
        axr(ADDR_COUNT);
        chk(rd, 32'h3);
        axw(ADDR_STATUS, 32'h8);
        repeat (3) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        // Counting halts before every mode or output change.
        axw(ADDR_CONTROL, 32'h0);
        axw(ADDR_MODE, 32'h0);
        axw(ADDR_MATCH0, 32'h3);
        axw(ADDR_OUTCTL, 32'h01);
        axw(ADDR_CONTROL, 32'h3);
        nextEdge(t0);
        nextEdge(t1);
        nextEdge(t2);
        chk(32'(t1 - t0), 32'h0C);
        chk(32'(t2 - t1), 32'h0C);
        axw(ADDR_CONTROL, 32'h0);
        axw(ADDR_STATUS, 32'hF);
        axw(ADDR_MATCH0, 32'h0);
        repeat (40) @(posedge clk);
        axr(ADDR_STATUS);
        chk(rd, 32'h0);
        axw(ADDR_MATCH0, 32'h5);
        axw(ADDR_MASK, 32'hE);
        axw(ADDR_CONTROL, 32'h9);
        waitIrq();
        chk({31'h0, irq}, 32'h1);
        axw(ADDR_STATUS, 32'h1);
        repeat (150) @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        axr(ADDR_CONTROL);
        chk({31'h0, rd[CTL_OVF]}, 32'h1);
        axw(ADDR_CONTROL, 32'h9);
        waitIrq();
        chk({31'h0, irq}, 32'h1);
        axw(ADDR_MASK, 32'hF);
        axw(ADDR_CONTROL, 32'h0);
        axw(ADDR_STATUS, 32'hF);
        axw(ADDR_OUTCTL, 32'h23);
        axw(ADDR_MATCH1, 32'h2);
        axw(ADDR_CONTROL, 32'h1);
        repeat (45) @(posedge clk);
        axr(ADDR_STATUS);
        chk(rd, 32'h3);
        chk({31'h0, irq}, 32'h0);
        axw(ADDR_CONTROL, 32'h0);
        repeat (4) @(posedge clk);
        chk({31'h0, timer_output_pins[0]}, 32'h1);
        tally_and_finish();
    end
endmodule : test_timer_event_counter_two
`default_nettype wire
